// file: cfg_pin_pkg.sv
// constants shared by the configuration pin mode selector
// assumes one 25 MHz clock domain and synchronous pin inputs
package cfg_pin_pkg;
  localparam int unsigned clk_period_ns = 40;
  localparam int unsigned frame_bits = 16;
  localparam int unsigned addr_bits = 4;
  localparam int unsigned data_bits = 12;
  localparam int unsigned num_regs = 16;
  // settings register address and field positions
  localparam logic [3:0] settings_addr = 4'h0;
  localparam int unsigned msb_inv_pos = 0;
  localparam int unsigned oe_a_pos = 1;
  localparam int unsigned pdn_pos = 2;
  // reset value: normal run, channel a driven, no invert
  localparam logic [11:0] settings_reset = 12'h000;
  localparam logic [11:0] reg_reset = 12'h000;
endpackage

// file: cfg_reg_mem.sv
// small register file holding the serial configuration words
// assumes writes come one at a time from the serial shifter
`timescale 1ns/1ps
module cfg_reg_mem #(
  parameter int unsigned depth = 16,
  parameter int unsigned width = 12,
  parameter int unsigned aw = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [aw-1:0] wr_addr,
  input wire logic [width-1:0] wr_data,
  input wire logic [aw-1:0] rd_addr,
  output logic [width-1:0] rd_data_ff
);
  logic [width-1:0] mem_ff [depth];
  logic [width-1:0] nxt_mem [depth];
  logic [width-1:0] nxt_rd_data;

  // clear returns every word to its default
  always_comb
  begin
    for (int i = 0; i < depth; i++)
    begin
      nxt_mem[i] = mem_ff[i];
      if (clr)
        nxt_mem[i] = cfg_pin_pkg::reg_reset;
      else if (wr_en && wr_addr == aw'(i))
        nxt_mem[i] = wr_data;
    end
    nxt_rd_data = clr ? cfg_pin_pkg::reg_reset : nxt_mem[rd_addr];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < depth; i++)
        mem_ff[i] <= cfg_pin_pkg::reg_reset;
      rd_data_ff <= cfg_pin_pkg::reg_reset;
    end
    else
    begin
      mem_ff <= nxt_mem;
      rd_data_ff <= nxt_rd_data;
    end
  end
endmodule

// file: config_pin_mode_select.sv
// configuration pin mode selector: three shared pins as parallel controls or a serial port
// assumes pins synchronous to clk; serial clock pin sampled and edge detected here
// Behaviour
// RQ1 - select low: shared pins are msb invert, channel a enable, power down
// RQ2 - select low: serial port inactive, serial pin activity ignored
// RQ3 - select high: pins become latch enable, shift clock, serial data
// RQ4 - host pulses select low after power-up to reset serial registers
// RQ5 - select low resets serial configuration registers to defaults
// RQ6 - power down input 0 runs normally, 1 powers down
// RQ7 - serial data is write-only, no read-back path exists
// RQ8 - channel b over-range indicator driven beside its results
// RQ9 - channel a enable 0 drives outputs, 1 makes them high impedance
// RQ10 - serial mode takes the three settings from serial registers
`timescale 1ns/1ps
module config_pin_mode_select #(
  parameter int unsigned frame_bits = cfg_pin_pkg::frame_bits
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_select,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_c,
  input wire logic chan_b_over_range_raw,
  output logic msb_invert_ff,
  output logic chan_a_output_enable_n_ff,
  output logic power_down_ff,
  output logic serial_active_ff,
  output logic chan_b_over_range_ff
);
  // pin aliases per mode
  logic msb_invert_input;
  logic chan_a_output_enable;
  logic power_down_input;
  logic serial_latch_enable;
  logic serial_shift_clock;
  logic serial_write_data;
  assign msb_invert_input = pin_a;
  assign chan_a_output_enable = pin_b;
  assign power_down_input = pin_c;
  assign serial_latch_enable = pin_a;
  assign serial_shift_clock = pin_b;
  assign serial_write_data = pin_c;

  // one-hot frame states; idle waits for latch enable to drop
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_shift = 2'b10
  } shift_state_t;

  // shifter state, bit count and the write strobe toward the store
  shift_state_t state_ff, nxt_state;
  logic sclk_d_ff, nxt_sclk_d;
  logic [frame_bits-1:0] shreg_ff, nxt_shreg;
  logic [4:0] cnt_ff, nxt_cnt;
  logic wr_en;
  logic [cfg_pin_pkg::addr_bits-1:0] wr_addr;
  logic [cfg_pin_pkg::data_bits-1:0] wr_data;
  logic [cfg_pin_pkg::data_bits-1:0] settings;
  logic sclk_rise;

  // gated by select so toggles of the enable pin in parallel mode never count as bits
  assign sclk_rise = serial_select && serial_shift_clock && !sclk_d_ff; // RQ3

  // serial shifter; latch enable low frames a word, written when it rises
  always_comb
  begin
    nxt_state = state_ff;
    nxt_shreg = shreg_ff;
    nxt_cnt = cnt_ff;
    nxt_sclk_d = serial_select ? serial_shift_clock : 1'b0;
    wr_en = 1'b0;
    case (state_ff)
      st_idle:
      begin
        if (serial_select && !serial_latch_enable) // RQ3
        begin
          nxt_state = st_shift;
          nxt_cnt = 5'h00;
        end
      end
      st_shift:
      begin
        if (sclk_rise && cnt_ff < 5'(frame_bits))
        begin
          nxt_shreg = {shreg_ff[frame_bits-2:0], serial_write_data}; // RQ7
          nxt_cnt = cnt_ff + 5'h01;
        end
        if (serial_latch_enable)
        begin
          nxt_state = st_idle;
          wr_en = (cnt_ff == 5'(frame_bits)); // short frames are dropped
        end
      end
      default:
        nxt_state = st_idle;
    endcase
    // select low holds the port idle and discards activity
    if (!serial_select) // RQ2
    begin
      nxt_state = st_idle;
      nxt_cnt = 5'h00;
      nxt_shreg = '0;
      wr_en = 1'b0;
    end
  end

  // top nibble picks the word, low twelve bits are its value
  assign wr_addr = shreg_ff[frame_bits-1 -: cfg_pin_pkg::addr_bits];
  assign wr_data = shreg_ff[cfg_pin_pkg::data_bits-1:0];

  // shifter registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= st_idle;
      shreg_ff <= '0;
      cnt_ff <= 5'h00;
      sclk_d_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      shreg_ff <= nxt_shreg;
      cnt_ff <= nxt_cnt;
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  // write-only store; only the settings word is read internally, never shifted out
  cfg_reg_mem #(
    .depth(cfg_pin_pkg::num_regs),
    .width(cfg_pin_pkg::data_bits),
    .aw(cfg_pin_pkg::addr_bits)
  ) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(!serial_select), // RQ5
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(cfg_pin_pkg::settings_addr),
    .rd_data_ff(settings)
  );

  logic nxt_msb_invert, nxt_oe_n, nxt_power_down, nxt_ovr;
  // mode mux: parallel pins when low, serial settings when high
  always_comb
  begin
    if (serial_select)
    begin
      nxt_msb_invert = settings[cfg_pin_pkg::msb_inv_pos]; // RQ10
      nxt_oe_n = settings[cfg_pin_pkg::oe_a_pos];
      nxt_power_down = settings[cfg_pin_pkg::pdn_pos];
    end
    else
    begin
      nxt_msb_invert = msb_invert_input; // RQ1
      nxt_oe_n = chan_a_output_enable; // RQ9
      nxt_power_down = power_down_input; // RQ6
    end
    nxt_ovr = chan_b_over_range_raw; // RQ8
  end

  // outputs leave flip-flops, costing one cycle but hiding pin glitches downstream
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      msb_invert_ff <= 1'b0;
      chan_a_output_enable_n_ff <= 1'b0;
      power_down_ff <= 1'b0;
      serial_active_ff <= 1'b0;
      chan_b_over_range_ff <= 1'b0;
    end
    else
    begin
      msb_invert_ff <= nxt_msb_invert;
      chan_a_output_enable_n_ff <= nxt_oe_n;
      power_down_ff <= nxt_power_down;
      serial_active_ff <= serial_select;
      chan_b_over_range_ff <= nxt_ovr;
    end
  end

  // checks
  chk_par_power_down: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
    !serial_select |=> power_down_ff == $past(pin_c)) else $error("power down not from pin");
  chk_par_oe_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
    !serial_select |=> chan_a_output_enable_n_ff == $past(pin_b)) else $error("oe a not from pin");
  chk_par_msb_inv: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    !serial_select |=> msb_invert_ff == $past(pin_a)) else $error("msb invert not from pin");
  chk_serial_idle: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
    !serial_select |=> state_ff == st_idle && cnt_ff == 5'h00) else $error("serial active while low");
  chk_no_write_low: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
    !serial_select |-> !wr_en) else $error("write while select low");
  chk_reset_regs: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
    !serial_select ##1 serial_select |-> settings == cfg_pin_pkg::settings_reset)
    else $error("settings not reset");
  chk_serial_settings: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
    serial_select |=> power_down_ff == $past(settings[cfg_pin_pkg::pdn_pos]))
    else $error("serial power down mismatch");
  chk_ovr_follow: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
    1'b1 |=> chan_b_over_range_ff == $past(chan_b_over_range_raw)) else $error("over range lag");
  chk_frame_start: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    state_ff == st_idle && serial_select && !pin_a |=> state_ff == st_shift) else $error("frame not opened");
  // serial settings reach the outputs one edge after the stored word
  chk_serial_msb_inv: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
    serial_select |=> msb_invert_ff == $past(settings[cfg_pin_pkg::msb_inv_pos]))
    else $error("serial msb invert mismatch");
  chk_serial_oe_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
    serial_select |=> chan_a_output_enable_n_ff == $past(settings[cfg_pin_pkg::oe_a_pos]))
    else $error("serial oe a mismatch");
  // a full frame at the settings address must show up in the stored word
  chk_write_lands: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    wr_en && wr_addr == cfg_pin_pkg::settings_addr |=> settings == $past(wr_data))
    else $error("settings write lost");
  chk_short_drop: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    state_ff == st_shift && pin_a && cnt_ff != 5'(frame_bits) |-> !wr_en)
    else $error("short frame written");
  chk_active_follow: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    1'b1 |=> serial_active_ff == $past(serial_select)) else $error("serial active lag");
  cov_serial_write: cover property (@(posedge clk) disable iff (sys_rst) wr_en);
  cov_select_pulse: cover property (@(posedge clk) disable iff (sys_rst) serial_select ##1 !serial_select ##1 serial_select);
  cov_par_pdn: cover property (@(posedge clk) disable iff (sys_rst) !serial_select && pin_c);
  cov_short_frame: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == st_shift && pin_a && cnt_ff != 5'(frame_bits));
endmodule

// file: host_model.sv
// host model driving the select input and the three shared pins
// assumes the device samples every pin on the rising edge of clk
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic serial_select,
  output logic pin_a,
  output logic pin_b,
  output logic pin_c
);
  // idle: parallel mode, all controls at their defaults
  initial
  begin
    serial_select = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    pin_c = 1'b0;
  end

  // parallel mode: the pins are plain control levels
  task automatic par(input logic [2:0] v);
    @(posedge clk);
    serial_select <= 1'b0;
    {pin_a, pin_b, pin_c} <= v;
  endtask

  // low pulse on select, latch enable parked high so no frame opens early
  task automatic pulse();
    @(posedge clk);
    serial_select <= 1'b0;
    pin_a <= 1'b1;
    pin_b <= 1'b0;
    @(posedge clk);
    serial_select <= 1'b1;
  endtask

  // one frame, msb first; n below 16 makes a frame the device drops
  task automatic frame(input logic [15:0] w, input int n);
    int i;
    @(posedge clk);
    pin_a <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk);
      pin_c <= w[15-i];
      pin_b <= 1'b0;
      @(posedge clk);
      pin_b <= 1'b1;
    end
    @(posedge clk);
    pin_b <= 1'b0;
    @(posedge clk);
    pin_a <= 1'b1;
    pin_c <= ~pin_c; // released data line must not keep the last bit
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the configuration pin mode selector
// assumes host_model drives the shared pins; bench drives over-range
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic raw = 1'b0;
  logic serial_select, pin_a, pin_b, pin_c;
  logic msb_q, oe_q, pd_q, act_q, ovr_q;
  logic [2:0] cur;
  logic [2:0] v;
  logic [15:0] w;
  int err_count = 0;
  int cmp_count = 0;

  always #(cfg_pin_pkg::clk_period_ns / 2) clk = ~clk;

  host_model u_host (.clk(clk), .serial_select(serial_select), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));

  config_pin_mode_select u_dut (.clk(clk), .sys_rst(sys_rst), .serial_select(serial_select), .pin_a(pin_a),
    .pin_b(pin_b), .pin_c(pin_c), .chan_b_over_range_raw(raw), .msb_invert_ff(msb_q),
    .chan_a_output_enable_n_ff(oe_q), .power_down_ff(pd_q), .serial_active_ff(act_q),
    .chan_b_over_range_ff(ovr_q));

  // one compare point so every check is counted
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // settings after a frame: only the settings address lands, as {msb, oe_n, pd}
  function automatic logic [2:0] exp_set(input logic [2:0] old, input logic [15:0] f);
    if (f[15:12] != cfg_pin_pkg::settings_addr)
      return old;
    return {f[cfg_pin_pkg::msb_inv_pos], f[cfg_pin_pkg::oe_a_pos], f[cfg_pin_pkg::pdn_pos]};
  endfunction

  // serial checks wait past the two-edge settings latency
  task automatic send(input logic [15:0] f, input int n);
    u_host.frame(f, n);
    if (n == 16)
      cur = exp_set(cur, f);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({act_q, msb_q, oe_q, pd_q}, {1'b1, cur});
  endtask

  initial
  begin
    void'($urandom(3416));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({msb_q, oe_q, pd_q, act_q}, 4'h0);
    // parallel mode, random pins and over-range
    repeat (40)
    begin
      v = 3'($urandom);
      u_host.par(v);
      raw <= 1'($urandom);
      @(posedge clk);
      @(negedge clk);
      chk({1'b0, msb_q, oe_q, pd_q}, {1'b0, v});
      chk({2'h0, act_q, ovr_q}, {3'h0, raw});
    end
    // serial mode, random frames, half of them at the settings address
    u_host.pulse();
    cur = exp_set(3'h0, {cfg_pin_pkg::settings_addr, cfg_pin_pkg::settings_reset});
    repeat (12)
    begin
      w = 16'($urandom);
      if ($urandom_range(1, 0) == 0)
        w[15:12] = cfg_pin_pkg::settings_addr;
      send(w, 16);
    end
    send({cfg_pin_pkg::settings_addr, 12'h007}, 16);
    send({cfg_pin_pkg::settings_addr, 12'h000}, 15);
    // select pulse must clear what the last full frame set
    u_host.pulse();
    cur = 3'h0;
    send(16'hf000, 15);
    give_verdict();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #(cfg_pin_pkg::clk_period_ns * 20000);
    err_count++;
    give_verdict();
  end
endmodule
